// ### logic/brc_sequencer.sv
// Purpose: control and protection sequencer of a synchronous buck regulator
// Assumes: analog comparators arrive as levels synchronous to mclk
// Notes:   one switching period is one protection clock
`timescale 1ns/1ps
`default_nettype none
module brc_sequencer #(
  parameter int unsigned RESET_HOLD_CYCLES = brc_pkg::RESET_HOLD_CYC,
  parameter int unsigned SOFTSTART_CYCLES  = brc_pkg::SOFTSTART_CLKS
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        enable,
  input  wire logic        syncIn,
  input  wire logic        supplyLockout,
  input  wire logic        supplyBelowReset,
  input  wire logic        currentTrip,
  input  wire logic        overCurrent,
  input  wire logic        overVoltage,
  input  wire logic        outputInWindow,
  input  wire logic        levelSelHigh,
  input  wire logic        levelSelLow,
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic [31:0]      regRdata,
  output logic             highSideOn,
  output logic             lowSideOn,
  output logic             driversOn,
  output logic             oscRunning,
  output logic             refEnable,
  output logic             rampSelect,
  output logic [11:0]      rampLevel,
  output logic [11:0]      vrefMv,
  output logic             regulationOk,
  output logic             regulationOkOe,
  output logic             resetOut_n
);
  localparam int unsigned SS_W  = $clog2(SOFTSTART_CYCLES + 1);
  localparam int unsigned RH_W  = $clog2(RESET_HOLD_CYCLES + 1);
  localparam int unsigned OSC_W = $clog2(brc_pkg::OSC_PERIOD_CYC + 1);
  localparam int unsigned SL_W  = $clog2(brc_pkg::SYNC_LOSS_CYC + 1);
  localparam int unsigned DT_W  = $clog2(brc_pkg::DEAD_CYC + 1);

  if (SOFTSTART_CYCLES < 2 || SS_W > 12 + 8 || RESET_HOLD_CYCLES < 1)
    $error("brc_sequencer: parameter out of range");

  typedef enum logic [1:0] {PW_OFF, PW_SOFT, PW_RUN, PW_WAIT} brc_power_t;
  typedef enum logic [1:0] {SW_IDLE, SW_HIGH, SW_DEAD, SW_LOW} brc_switch_t;

  // =====================================================================
  // register file
  logic [1:0]  ctrl;
  logic [1:0]  next_ctrl;
  logic [31:0] next_regRdata;
  logic [31:0] status;

  // =====================================================================
  // clock selection state
  logic             syncPrev;
  logic             next_syncPrev;
  logic             syncLocked;
  logic             next_syncLocked;
  logic [SL_W-1:0]  syncGap;
  logic [SL_W-1:0]  next_syncGap;
  logic [OSC_W-1:0] oscCnt;
  logic [OSC_W-1:0] next_oscCnt;
  logic             syncRise;
  logic             cycleTick;

  // =====================================================================
  // power and switching state
  brc_power_t       power;
  brc_power_t       next_power;
  brc_switch_t      sw;
  brc_switch_t      next_sw;
  logic [DT_W-1:0]  deadCnt;
  logic [DT_W-1:0]  next_deadCnt;
  logic [SS_W-1:0]  ssCnt;
  logic [SS_W-1:0]  next_ssCnt;
  logic [3:0]       faultCnt;
  logic [3:0]       next_faultCnt;
  logic [4:0]       waitCnt;
  logic [4:0]       next_waitCnt;
  logic [5:0]       ovCnt;
  logic [5:0]       next_ovCnt;
  logic [RH_W-1:0]  holdCnt;
  logic [RH_W-1:0]  next_holdCnt;
  logic             next_resetOut_n;
  logic             next_regulationOk;
  logic [11:0]      next_vrefMv;
  logic             switchAllowed;
  logic             poweredUp;

  function automatic logic [11:0] level_mv(input logic hiVar, input logic hi, input logic lo);
    logic [11:0] mv;
    mv = brc_pkg::VOUT_LOW;
    if (hi) begin
      mv = hiVar ? brc_pkg::VOUT_HI_HIGH : brc_pkg::VOUT_LO_HIGH;
    end else if (!lo) begin
      mv = hiVar ? brc_pkg::VOUT_HI_OPEN : brc_pkg::VOUT_LO_OPEN;
    end
    return mv;
  endfunction

  // =====================================================================
  // register port
  always_comb begin
    next_ctrl     = ctrl;
    next_regRdata = 32'h0000_0000;
    if (regWrite && regAddr == brc_pkg::REG_CTRL) begin
      next_ctrl = regWdata[1:0];
    end
    if (regRead) begin
      if (regAddr == brc_pkg::REG_CTRL) begin
        next_regRdata = {30'h0000_0000, ctrl};
      end else if (regAddr == brc_pkg::REG_STATUS) begin
        next_regRdata = status;
      end else begin
        next_regRdata = 32'h0000_0000;
      end
    end
  end

  always_comb begin
    status = 32'h0000_0000;
    status[brc_pkg::ST_SYNC]                      = syncLocked;
    status[brc_pkg::ST_SS_DONE]                   = (power == PW_RUN);
    status[brc_pkg::ST_REG_OK]                    = regulationOk;
    status[brc_pkg::ST_RESET_N]                   = resetOut_n;
    status[brc_pkg::ST_FAULT_LO +: 4]             = faultCnt;
    status[brc_pkg::ST_OC_WAIT]                   = (power == PW_WAIT);
    status[brc_pkg::ST_RUN]                       = switchAllowed;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl     <= brc_pkg::CTRL_RESET;
      regRdata <= 32'h0000_0000;
    end else begin
      ctrl     <= next_ctrl;
      regRdata <= next_regRdata;
    end
  end

  // =====================================================================
  // switching clock: internal oscillator or external sync
  assign poweredUp = enable && !supplyLockout;
  assign syncRise  = syncIn && !syncPrev;

  always_comb begin
    next_syncPrev   = syncIn;
    next_syncLocked = syncLocked;
    next_syncGap    = syncGap;
    next_oscCnt     = oscCnt;
    cycleTick       = 1'b0;
    if (!poweredUp) begin
      // oscillator stopped in shutdown
      next_syncLocked = 1'b0;
      next_syncGap    = '0;
      next_oscCnt     = '0;
    end else if (syncRise && !ctrl[brc_pkg::CTRL_FORCE_INT]) begin
      // first edge locks and starts a cycle at once
      next_syncLocked = 1'b1;
      next_syncGap    = '0;
      next_oscCnt     = '0;
      cycleTick       = 1'b1;
    end else begin
      if (syncLocked) begin
        if (syncGap >= SL_W'(brc_pkg::SYNC_LOSS_CYC - 1)) begin
          // phase carries on from the last edge; no cycle starts until the loss timeout ends and the oscillator wraps
          next_syncLocked = 1'b0;
        end else begin
          next_syncGap = syncGap + SL_W'(1);
        end
      end
      if (oscCnt >= OSC_W'(brc_pkg::OSC_PERIOD_CYC - 1)) begin
        next_oscCnt = '0;
        cycleTick   = !next_syncLocked || !syncLocked;
      end else begin
        next_oscCnt = oscCnt + OSC_W'(1);
      end
      if (ctrl[brc_pkg::CTRL_FORCE_INT]) begin
        next_syncLocked = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      syncPrev   <= 1'b0;
      syncLocked <= 1'b0;
      syncGap    <= '0;
      oscCnt     <= '0;
    end else begin
      syncPrev   <= next_syncPrev;
      syncLocked <= next_syncLocked;
      syncGap    <= next_syncGap;
      oscCnt     <= next_oscCnt;
    end
  end

  // =====================================================================
  // power sequence: soft-start, run, protection restarts
  always_comb begin
    next_power    = power;
    next_ssCnt    = ssCnt;
    next_faultCnt = faultCnt;
    next_waitCnt  = waitCnt;
    next_ovCnt    = ovCnt;
    if (!poweredUp) begin
      next_power    = PW_OFF;
      next_ssCnt    = '0;
      next_faultCnt = brc_pkg::FAULT_MIN;
      next_waitCnt  = '0;
      next_ovCnt    = '0;
    end else if (power == PW_OFF) begin
      next_power = PW_SOFT;
      next_ssCnt = '0;
    end else if (cycleTick) begin
      // all protection counting runs on the switching clock
      if (power != PW_WAIT) begin
        if (overCurrent && faultCnt != brc_pkg::FAULT_MAX) begin
          next_faultCnt = faultCnt + 4'h1;
        end else if (!overCurrent && faultCnt != brc_pkg::FAULT_MIN) begin
          next_faultCnt = faultCnt - 4'h1;
        end
        next_ovCnt = overVoltage ? ovCnt + 6'h01 : 6'h00;
      end
      case (power)
        PW_SOFT: begin
          if (ssCnt >= SS_W'(SOFTSTART_CYCLES - 1)) begin
            next_power = PW_RUN;
          end else begin
            next_ssCnt = ssCnt + SS_W'(1);
          end
        end
        PW_WAIT: begin
          if (waitCnt >= 5'(brc_pkg::OC_WAIT_CLKS - 1)) begin
            next_power    = PW_SOFT;
            next_waitCnt  = '0;
            next_faultCnt = brc_pkg::FAULT_MIN;
          end else begin
            next_waitCnt = waitCnt + 5'h01;
          end
        end
        default: begin
        end
      endcase
      if (power != PW_WAIT && next_faultCnt == brc_pkg::FAULT_MAX) begin
        next_power   = PW_WAIT;
        next_ssCnt   = '0;
        next_waitCnt = '0;
        next_ovCnt   = '0;
      end else if (power != PW_WAIT && next_ovCnt == 6'(brc_pkg::OV_PERSIST_CLKS)) begin
        next_power = PW_SOFT;
        next_ssCnt = '0;
        next_ovCnt = '0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      power    <= PW_OFF;
      ssCnt    <= '0;
      faultCnt <= brc_pkg::FAULT_MIN;
      waitCnt  <= '0;
      ovCnt    <= '0;
    end else begin
      power    <= next_power;
      ssCnt    <= next_ssCnt;
      faultCnt <= next_faultCnt;
      waitCnt  <= next_waitCnt;
      ovCnt    <= next_ovCnt;
    end
  end

  // =====================================================================
  // per-cycle switch sequence
  // reset output takes no part here: switching stops on disable, lockout, or outside soft-start and run
  assign switchAllowed = poweredUp && (power == PW_SOFT || power == PW_RUN);

  always_comb begin
    next_sw      = sw;
    next_deadCnt = deadCnt;
    if (!switchAllowed) begin
      next_sw      = SW_IDLE;
      next_deadCnt = '0;
    end else if (cycleTick) begin
      next_sw = SW_HIGH;
    end else begin
      case (sw)
        SW_HIGH: begin
          // the trip comparator carries the 1300mA peak limit too
          if (currentTrip) begin
            next_sw      = SW_DEAD;
            next_deadCnt = '0;
          end
        end
        SW_DEAD: begin
          if (deadCnt >= DT_W'(brc_pkg::DEAD_CYC - 1)) begin
            next_sw = SW_LOW;
          end else begin
            next_deadCnt = deadCnt + DT_W'(1);
          end
        end
        // low side holds to cycle end even if current reverses
        SW_LOW:  next_sw = SW_LOW;
        default: next_sw = SW_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sw         <= SW_IDLE;
      deadCnt    <= '0;
      highSideOn <= 1'b0;
      lowSideOn  <= 1'b0;
    end else begin
      sw         <= next_sw;
      deadCnt    <= next_deadCnt;
      highSideOn <= (next_sw == SW_HIGH);
      lowSideOn  <= (next_sw == SW_LOW);
    end
  end

  // =====================================================================
  // reference, ramp, regulation ok and reset supervisor
  always_comb begin
    next_vrefMv       = level_mv(ctrl[brc_pkg::CTRL_VARIANT], levelSelHigh, levelSelLow);
    next_regulationOk = poweredUp && outputInWindow;
    next_holdCnt      = holdCnt;
    next_resetOut_n   = resetOut_n;
    if (supplyBelowReset) begin
      next_holdCnt    = '0;
      next_resetOut_n = 1'b0;
    end else if (!resetOut_n) begin
      if (holdCnt >= RH_W'(RESET_HOLD_CYCLES - 1)) begin
        next_resetOut_n = 1'b1;
      end else begin
        next_holdCnt = holdCnt + RH_W'(1);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      holdCnt      <= '0;
      resetOut_n   <= 1'b0;
      regulationOk <= 1'b0;
      vrefMv       <= brc_pkg::VOUT_LOW;
      driversOn    <= 1'b0;
      oscRunning   <= 1'b0;
      refEnable    <= 1'b0;
      rampSelect   <= 1'b1;
      rampLevel    <= 12'h000;
    end else begin
      holdCnt      <= next_holdCnt;
      resetOut_n   <= next_resetOut_n;
      regulationOk <= next_regulationOk;
      vrefMv       <= next_vrefMv;
      driversOn    <= (next_power == PW_SOFT || next_power == PW_RUN);
      oscRunning   <= poweredUp;
      refEnable    <= poweredUp;
      rampSelect   <= (next_power != PW_RUN);
      // top bits of the soft-start count form the ramp seen by the amplifier
      rampLevel    <= (next_power == PW_RUN) ? 12'hFFF : 12'(({12'h000, next_ssCnt} << 12) >> SS_W);
    end
  end

  // open drain: pull low whenever not ok
  assign regulationOkOe = !regulationOk;
endmodule
`default_nettype wire

// ### logic/brc_pkg.sv
// Purpose: shared constants for the buck regulator control sequencer
// Assumes: mclk runs at 40 MHz
// Notes:   times are kept in their own unit, cycle counts derive from them
package brc_pkg;
  // =====================================================================
  // clock and timing
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned OSC_HZ          = 750_000;
  localparam int unsigned SYNC_MIN_HZ     = 500_000;
  localparam int unsigned SYNC_MAX_HZ     = 1_000_000;
  localparam int unsigned SYNC_LOSS_EDGES = 4;
  localparam int unsigned DEAD_NS         = 25;
  localparam int unsigned RESET_HOLD_MS   = 25;
  localparam int unsigned SOFTSTART_CLKS  = 4096;
  localparam int unsigned OC_WAIT_CLKS    = 16;
  localparam int unsigned OV_PERSIST_CLKS = 32;
  // longest period: round down
  localparam int unsigned OSC_PERIOD_CYC  = CLK_HZ / OSC_HZ;
  localparam int unsigned SYNC_LOSS_CYC   = SYNC_LOSS_EDGES * (CLK_HZ / SYNC_MIN_HZ);
  // least times: round up, at least one cycle
  localparam int unsigned DEAD_CYC_RAW    = (DEAD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned DEAD_CYC        = (DEAD_CYC_RAW < 1) ? 1 : DEAD_CYC_RAW;
  localparam int unsigned RESET_HOLD_CYC  = RESET_HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned PEAK_LIMIT_MA   = 1300;

  // =====================================================================
  // fault counter
  localparam logic [3:0] FAULT_MIN = 4'h0;
  localparam logic [3:0] FAULT_MAX = 4'hF;

  // =====================================================================
  // output level presets in millivolts, index {higherVariant, level}
  localparam logic [11:0] VOUT_LO_HIGH = 12'h708; // 1800 mV
  localparam logic [11:0] VOUT_LO_OPEN = 12'h5DC; // 1500 mV
  localparam logic [11:0] VOUT_HI_HIGH = 12'hCE4; // 3300 mV
  localparam logic [11:0] VOUT_HI_OPEN = 12'h708; // 1800 mV
  localparam logic [11:0] VOUT_LOW     = 12'h4B0; // 1200 mV

  typedef enum logic [1:0] {LEVEL_LOW, LEVEL_OPEN, LEVEL_HIGH} brc_level_t;

  // =====================================================================
  // register port
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int unsigned CTRL_FORCE_INT = 0;
  localparam int unsigned CTRL_VARIANT   = 1;
  localparam logic [1:0]  CTRL_RESET     = 2'h0;
  localparam int unsigned ST_SYNC     = 0;
  localparam int unsigned ST_SS_DONE  = 1;
  localparam int unsigned ST_REG_OK   = 2;
  localparam int unsigned ST_RESET_N  = 3;
  localparam int unsigned ST_FAULT_LO = 4;
  localparam int unsigned ST_OC_WAIT  = 8;
  localparam int unsigned ST_RUN      = 9;
endpackage

// ### test/brc_sync_src.sv
// Purpose: external sync clock source facing the sequencer
// Assumes: period and high time are given in mclk cycles
// Notes:   stopped source drives the line low, as a halted CMOS clock does
`timescale 1ns/1ps
`default_nettype none
module brc_sync_src (
  input  wire logic       mclk,
  input  wire logic       run,
  input  wire logic [7:0] period,
  input  wire logic [7:0] highCyc,
  output logic            syncIn
);
  logic [7:0] phase = 8'h00;
  // =====================================================================
  // caller keeps 500kHz..1MHz and 20..60 percent duty
  always_ff @(posedge mclk) begin
    if (!run || phase >= period - 8'h01) begin
      phase <= 8'h00;
    end else begin
      phase <= phase + 8'h01;
    end
    syncIn <= run && (phase < highCyc);
  end
endmodule
`default_nettype wire

// ### test/brc_sequencer_sva.sv
// Purpose: port-level checker of the regulator sequencer
// Assumes: one clock domain, synchronous active-low reset
// Notes:   shutdown, lockout, regulation ok and low level outputs are checked after two stable input samples
`timescale 1ns/1ps
`default_nettype none
module brc_sequencer_sva #(
  parameter int unsigned RESET_HOLD_CYCLES = 20
) (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        enable,
  input wire logic        supplyLockout,
  input wire logic        supplyBelowReset,
  input wire logic        currentTrip,
  input wire logic        outputInWindow,
  input wire logic        levelSelHigh,
  input wire logic        levelSelLow,
  input wire logic        highSideOn,
  input wire logic        lowSideOn,
  input wire logic        driversOn,
  input wire logic        oscRunning,
  input wire logic        refEnable,
  input wire logic        rampSelect,
  input wire logic [11:0] rampLevel,
  input wire logic [11:0] vrefMv,
  input wire logic        regulationOk,
  input wire logic        regulationOkOe,
  input wire logic        resetOut_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // =====================================================================
  // cycles since supply went good; saturates so it never wraps
  logic [31:0] okCnt;
  logic [31:0] next_okCnt;
  always_comb begin
    next_okCnt = okCnt;
    if (!rst_n || supplyBelowReset) begin
      next_okCnt = 32'h0000_0000;
    end else if (okCnt != 32'hFFFF_FFFF) begin
      next_okCnt = okCnt + 32'h0000_0001;
    end
  end
  always_ff @(posedge mclk) begin
    okCnt <= next_okCnt;
  end
  // =====================================================================
  AST_SHUTDOWN: assert property (!enable [*2] |=> !oscRunning && !refEnable && !driversOn && !highSideOn) else $error("blocks still on while disabled");
  AST_ENABLE_ON: assert property (enable && !supplyLockout |=> oscRunning && refEnable) else $error("oscillator not on");
  AST_LOCKOUT: assert property (supplyLockout [*2] |=> !highSideOn && !lowSideOn) else $error("switching under lockout");
  AST_PG_LOW: assert property (!(enable && outputInWindow) [*2] |=> !regulationOk) else $error("regulation ok high");
  AST_PG_OE: assert property (regulationOkOe == !regulationOk) else $error("open drain enable wrong");
  AST_TRIP: assert property (highSideOn && currentTrip |=> !highSideOn) else $error("high side not off after trip");
  AST_DEAD: assert property ($fell(highSideOn) |-> !lowSideOn) else $error("no dead time");
  AST_NO_OVERLAP: assert property (!(highSideOn && lowSideOn)) else $error("both switches on");
  AST_RAMP_DONE: assert property (!rampSelect |-> rampLevel == 12'hFFF) else $error("ramp not full in run");
  AST_LEVEL_LOW: assert property ((levelSelLow && !levelSelHigh) [*2] |=> vrefMv == brc_pkg::VOUT_LOW) else $error("low level wrong");
  AST_RST_OUT: assert property (supplyBelowReset |=> !resetOut_n) else $error("reset output not asserted");
  AST_RST_HOLD: assert property ($rose(resetOut_n) |-> okCnt >= RESET_HOLD_CYCLES - 1) else $error("reset released early");
  COV_TICK: cover property ($rose(highSideOn));
  COV_SS_DONE: cover property ($fell(rampSelect));
  COV_RST_REL: cover property ($rose(resetOut_n));
endmodule
bind brc_sequencer brc_sequencer_sva #(.RESET_HOLD_CYCLES(RESET_HOLD_CYCLES)) i_brc_sequencer_sva (.*);
`default_nettype wire

// ### test/tb_brc_sequencer.sv
// Purpose: self-checking bench of the regulator sequencer
// Assumes: short hold and soft-start counts, 40 MHz mclk
// Notes:   current trip is modelled one cycle after high side turns on
`timescale 1ns/1ps
`default_nettype none
module tb_brc_sequencer;
  localparam int unsigned HOLD = 20;
  localparam int unsigned SS = 8;
  // first internal tick after sync loss lands within one oscillator period of the timeout
  localparam int LOSS_LO = brc_pkg::SYNC_LOSS_CYC - brc_pkg::OSC_PERIOD_CYC;
  localparam int LOSS_HI = brc_pkg::SYNC_LOSS_CYC + brc_pkg::OSC_PERIOD_CYC;
  logic mclk, rst_n, enable, supplyLockout, supplyBelowReset, currentTrip;
  logic overCurrent, overVoltage, outputInWindow, levelSelHigh, levelSelLow;
  logic regWrite, regRead, highSideOn, lowSideOn, driversOn, oscRunning;
  logic refEnable, rampSelect, regulationOk, regulationOkOe, resetOut_n;
  logic syncIn, syncRun;
  logic [3:0] regAddr;
  logic [31:0] regWdata, regRdata, d;
  logic [11:0] rampLevel, vrefMv;
  int err_total = 0;
  int checks_done = 0;
  int gap;
  brc_sequencer #(.RESET_HOLD_CYCLES(HOLD), .SOFTSTART_CYCLES(SS)) i_brc_sequencer (.*);
  brc_sync_src i_brc_sync_src (.mclk(mclk), .run(syncRun), .period(8'h32),
    .highCyc(8'h14), .syncIn(syncIn));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) currentTrip <= highSideOn;
  // =====================================================================
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge mclk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= v;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic wait_hs(input logic v);
    int g;
    g = 0;
    while (highSideOn !== v) begin
      @(posedge mclk);
      #1 g++;
      gap++;
      if (g > 3000) begin
        err_total++;
        $display("mismatch highSideOn expected %h seen %h", v, highSideOn);
        give_verdict();
      end
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      wait_hs(1'b0);
      wait_hs(1'b1);
    end
  endtask
  // =====================================================================
  task automatic t_start();
    rd(4'h4);
    chk(d, 32'h0000_0000, "status at reset");
    rd(4'h8);
    chk(d, 32'h0000_0000, "unmapped read");
    wr(4'h0, 32'hFFFF_FFFF);
    rd(4'h0);
    chk(d, 32'h0000_0003, "ctrl");
    wr(4'h0, 32'h0000_0001);
    enable <= 1'b1;
    ticks(5);
    chk(rampSelect, 1'b1, "ramp in soft start");
    chk(rampLevel > 12'h000 && rampLevel < 12'hFFF, 1, "ramp rising");
    ticks(6);
    chk(rampSelect, 1'b0, "ramp after soft start");
    chk(rampLevel, 12'hFFF, "ramp level");
    gap = 0;
    ticks(1);
    chk(gap, brc_pkg::OSC_PERIOD_CYC, "internal period");
    repeat (40) @(posedge mclk);
    #1 chk(lowSideOn, 1'b1, "low side to cycle end");
    outputInWindow <= 1'b1;
    repeat (3) @(posedge mclk);
    #1 chk(regulationOk, 1'b1, "regulation ok");
  endtask
  task automatic t_fault();
    @(posedge mclk);
    overCurrent <= 1'b1;
    ticks(3);
    @(posedge mclk);
    overCurrent <= 1'b0;
    rd(4'h4);
    chk(d[7:4], 4'h3, "fault count up");
    ticks(5);
    rd(4'h4);
    chk(d[7:4], 4'h0, "fault count floor");
    overCurrent <= 1'b1;
    ticks(14);
    repeat (60) @(posedge mclk);
    overCurrent <= 1'b0;
    rd(4'h4);
    chk({d[8], d[7:4], highSideOn, rampSelect}, 7'h7D, "overcurrent stop");
    gap = 0;
    ticks(1);
    chk(gap > 700 && gap < 900, 1, "restart delay");
    rd(4'h4);
    chk({d[7:4], rampSelect}, 5'h01, "restart soft start");
    ticks(10);
    overVoltage <= 1'b1;
    ticks(30);
    chk(rampSelect, 1'b0, "short overvoltage");
    ticks(4);
    chk(rampSelect, 1'b1, "overvoltage restart");
    overVoltage <= 1'b0;
  endtask
  task automatic t_level();
    logic [11:0] ev [6];
    ev = '{brc_pkg::VOUT_LOW, brc_pkg::VOUT_LO_OPEN, brc_pkg::VOUT_LO_HIGH,
      brc_pkg::VOUT_LOW, brc_pkg::VOUT_HI_OPEN, brc_pkg::VOUT_HI_HIGH};
    for (int i = 0; i < 6; i++) begin
      wr(4'h0, (i > 2) ? 32'h0000_0003 : 32'h0000_0001);
      levelSelLow <= (i % 3 == 0);
      levelSelHigh <= (i % 3 == 2);
      repeat (3) @(posedge mclk);
      #1 chk(vrefMv, ev[i], "output level");
    end
  endtask
  task automatic t_sync();
    wr(4'h0, 32'h0000_0000);
    syncRun <= 1'b1;
    ticks(3);
    gap = 0;
    ticks(1);
    chk(gap, 50, "sync period");
    rd(4'h4);
    chk(d[0], 1'b1, "sync locked");
    syncRun <= 1'b0;
    gap = 0;
    ticks(1);
    chk(gap >= LOSS_LO && gap <= LOSS_HI, 1, "fallback delay");
    repeat (8) begin
      gap = 0;
      ticks(1);
      chk(gap, brc_pkg::OSC_PERIOD_CYC, "fallback period");
    end
    rd(4'h4);
    chk(d[0], 1'b0, "sync lost");
  endtask
  task automatic t_supply();
    supplyBelowReset <= 1'b1;
    repeat (2) @(posedge mclk);
    #1 chk(resetOut_n, 1'b0, "reset asserted");
    ticks(2);
    @(posedge mclk);
    supplyBelowReset <= 1'b0;
    gap = 0;
    while (resetOut_n !== 1'b1 && gap < 100) begin
      @(posedge mclk);
      #1 gap++;
    end
    chk(gap >= HOLD && gap <= HOLD + 2, 1, "reset hold");
    supplyLockout <= 1'b1;
    gap = 0;
    repeat (200) begin
      @(posedge mclk);
      #1 gap += (highSideOn === 1'b1);
    end
    chk(gap <= 2, 1, "lockout");
    chk(oscRunning, 1'b0, "lockout osc");
    supplyLockout <= 1'b0;
    ticks(2);
    enable <= 1'b0;
    repeat (3) @(posedge mclk);
    #1 chk({highSideOn, driversOn, oscRunning, refEnable, regulationOk}, 0, "shutdown");
  endtask
  // =====================================================================
  initial begin
    {rst_n, enable, supplyLockout, supplyBelowReset, syncRun} = 5'h00;
    {overCurrent, overVoltage, outputInWindow, levelSelHigh, levelSelLow} = 5'h00;
    {regWrite, regRead, regAddr, regWdata} = 38'h0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    t_start();
    t_fault();
    t_level();
    t_sync();
    t_supply();
    give_verdict();
  end
endmodule
`default_nettype wire
